// ==== core/ddr_sio_consts.svh ====
// Purpose: named constants for the separate-io burst sram port
// Assumes: included by the package and the design modules
// Notes: widths follow the narrow organisation, two words per burst
`ifndef DDR_SIO_CONSTS_SVH
`define DDR_SIO_CONSTS_SVH

// data and address widths
`define WORD_W        18
`define ADDR_W        19
`define LANE_W        9
`define LANES         2
`define BURST_W       36
`define BURST_LANES   4
`define DEPTH         524288

// pin synchroniser bit positions and reset value
`define PIN_LOOP      2
`define PIN_CLK_P     1
`define PIN_CLK_N     0
`define PIN_SYNC_RST  3'h7

// strap capture wait, counted after reset release
`define STRAP_WAIT    2'h3
`define STRAP_CNT_RST 2'h0

// reset values
`define WORD_RST      18'h00000
`define ADDR_RST      19'h00000
`define LANE_RST      2'h3
`define BURST_RST     36'h000000000
`define STATUS_RST    2'h0

`endif

// ==== core/ddr_sio_pkg.sv ====
// Purpose: types shared by the sram port modules
// Assumes: constants header is on the include path
// Notes: none
`include "ddr_sio_consts.svh"

package ddr_sio_pkg;

    typedef logic [`WORD_W-1:0]  word_t;
    typedef logic [`ADDR_W-1:0]  addr_t;
    typedef logic [`LANES-1:0]   lane_t;
    typedef logic [`BURST_W-1:0] burst_t;
    typedef logic [`BURST_LANES-1:0] burst_lane_t;

    // read latency mode picked by the loop-disable pin
    typedef enum logic {
        MODE_LOOP,
        MODE_COMPAT
    } mode_t;

endpackage

// ==== core/sio_mem_if.sv ====
// Purpose: carrier between the port logic and the storage array
// Assumes: all signals belong to the link clock domain
// Notes: one read port, one write port with lane enables
`timescale 1ns/1ps

interface sio_mem_if;
    import ddr_sio_pkg::*;

    logic        re;
    addr_t       raddr;
    burst_t      rdata;
    logic        we;
    addr_t       waddr;
    burst_t      wdata;
    burst_lane_t wbe;

    modport ctrl
    (
        output re,
        output raddr,
        input  rdata,
        output we,
        output waddr,
        output wdata,
        output wbe
    );

    modport mem
    (
        input  re,
        input  raddr,
        output rdata,
        input  we,
        input  waddr,
        input  wdata,
        input  wbe
    );
endinterface

// ==== core/sio_array.sv ====
// Purpose: burst-wide storage array with registered read data
// Assumes: one clock, read and write ports independent
// Notes: lanes not enabled keep their stored value
`timescale 1ns/1ps
`include "ddr_sio_consts.svh"

module sio_array
    import ddr_sio_pkg::*;
(
    // link clock
    input  wire logic k_clk,
    // storage port
    sio_mem_if.mem    port
);

    // per-lane storage, masked write and registered read
    genvar g;
    generate
        for (g = 0; g < `BURST_LANES; g = g + 1)
        begin : g_lane
            logic [`LANE_W-1:0] lane_arr [`DEPTH];

            always_ff @(posedge k_clk)
            begin
                if (port.we && port.wbe[g])
                begin
                    lane_arr[port.waddr] <= port.wdata[g*`LANE_W +: `LANE_W];
                end
                if (port.re)
                begin
                    port.rdata[g*`LANE_W +: `LANE_W] <= lane_arr[port.raddr];
                end
            end
        end
    endgenerate

endmodule

// ==== core/ddr_sio_port.sv ====
// Purpose: clocking, registering and read latency of a ddr separate-io burst sram port
// Assumes: controls and data are synchronous to k_clk; falling k_clk stands for the
//          rising edge of the complementary clock; output pair is zero-skew with k
// Notes on behaviour
// - the internal delay loop is off while loop_disable_n is low and on while it is high.
// - with the loop off the port runs in the compatible mode with its own latency.
// - with loop_disable_n high, read data appears one and a half cycles after the load.
// - with loop_disable_n low, read data appears one full cycle after the load.
// - accesses start only at a rising edge of the true input clock.
// - synchronous inputs are sampled on rising edges of the true and complement clocks.
// - outputs are timed from the output clock pair, or the input pair in single-clock mode; here q_out follows k_clk in both, the pair only sets the strap.
// - write data is captured on both input clock edges, two words per cycle.
// - read data leaves through output registers on both output clock edges; here q_p_reg is clocked on the rising and q_n_reg on the falling k_clk edge.
// - direction and load are registered on the true clock rising edge only; lane masks are taken on both edges with the data.
// - with load low, direction high asks for a read and direction low for a write.
// - every transaction moves a burst of two words at the loaded address in one cycle.
`timescale 1ns/1ps
`include "ddr_sio_consts.svh"

module ddr_sio_port
    import ddr_sio_pkg::*;
(
    // system clock and reset
    input  wire logic  clk,
    input  wire logic  arst_n,
    // link clock and static pins
    input  wire logic  k_clk,
    input  wire logic  out_clk_p,
    input  wire logic  out_clk_n,
    input  wire logic  loop_disable_n,
    // controls and write data
    input  wire logic  load_strobe_n,
    input  wire logic  rw_dir,
    input  wire addr_t address,
    input  wire word_t d_in,
    input  wire lane_t byte_lane_mask_n,
    // read data
    output word_t      q_out,
    output logic       q_oe_n,
    // status in the system domain
    output logic       loop_off_status,
    output logic       single_clock_status
);

    sio_mem_if mif();

    logic        k_rst_s1_reg;
    logic        k_rst_n;
    logic [2:0]  pin_s1_reg;
    logic [2:0]  pin_s2_reg;
    logic [1:0]  strap_cnt_reg;
    logic        strap_done_reg;
    logic        single_clk_reg;
    logic        rd1_reg;
    logic        rd2_reg;
    logic        wr1_reg;
    logic        wr2_reg;
    burst_t      rbuf_reg;
    addr_t       waddr1_reg;
    addr_t       waddr2_reg;
    word_t       d0_reg;
    word_t       d1_reg;
    lane_t       m0_reg;
    lane_t       m1_reg;
    word_t       q_p_reg;
    word_t       q_n_reg;
    logic        q_p_vld_reg;
    logic        q_n_vld_reg;
    logic [1:0]  status_s1_reg;
    logic [1:0]  status_s2_reg;

    wire logic   dll_off;
    wire mode_t  mode;
    wire logic   rd_load;
    wire logic   wr_load;
    wire word_t  rdata_lo;
    wire word_t  rdata_hi;
    wire word_t  rbuf_lo;
    wire word_t  rbuf_hi;

    // link reset, released on the link clock
    always_ff @(posedge k_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            k_rst_s1_reg <= 1'b0;
            k_rst_n      <= 1'b0;
        end
        else
        begin
            k_rst_s1_reg <= 1'b1;
            k_rst_n      <= k_rst_s1_reg;
        end
    end

    // static pins through two flops
    always_ff @(posedge k_clk or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            pin_s1_reg <= `PIN_SYNC_RST;
            pin_s2_reg <= `PIN_SYNC_RST;
        end
        else
        begin
            pin_s1_reg <= {loop_disable_n, out_clk_p, out_clk_n};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    assign dll_off = ~pin_s2_reg[`PIN_LOOP];
    assign mode    = dll_off ? MODE_COMPAT : MODE_LOOP;

    always_ff @(posedge k_clk or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            strap_cnt_reg  <= `STRAP_CNT_RST;
            strap_done_reg <= 1'b0;
            single_clk_reg <= 1'b0;
        end
        else if (!strap_done_reg)
        begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == `STRAP_WAIT)
            begin
                strap_done_reg <= 1'b1;
                single_clk_reg <= pin_s2_reg[`PIN_CLK_P] & pin_s2_reg[`PIN_CLK_N];
            end
        end
    end

    assign rd_load = ~load_strobe_n & rw_dir;
    assign wr_load = ~load_strobe_n & ~rw_dir;

    // read port fed from the loaded address
    assign mif.re    = rd_load;
    assign mif.raddr = address;
    assign rdata_lo  = mif.rdata[`WORD_W-1:0];
    assign rdata_hi  = mif.rdata[`BURST_W-1:`WORD_W];
    assign rbuf_lo   = rbuf_reg[`WORD_W-1:0];
    assign rbuf_hi   = rbuf_reg[`BURST_W-1:`WORD_W];

    // controls taken on the true rising edge
    always_ff @(posedge k_clk or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            rd1_reg <= 1'b0;
            rd2_reg <= 1'b0;
            wr1_reg <= 1'b0;
            wr2_reg <= 1'b0;
        end
        else
        begin
            rd1_reg <= rd_load;
            rd2_reg <= rd1_reg;
            wr1_reg <= wr_load;
            wr2_reg <= wr1_reg;
        end
    end

    // address held from the loading edge
    always_ff @(posedge k_clk or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            waddr1_reg <= `ADDR_RST;
            waddr2_reg <= `ADDR_RST;
            rbuf_reg   <= `BURST_RST;
        end
        else
        begin
            waddr1_reg <= wr_load ? address : waddr1_reg;
            waddr2_reg <= waddr1_reg;
            rbuf_reg   <= rd1_reg ? mif.rdata : rbuf_reg;
        end
    end

    // first word on the true edge
    always_ff @(posedge k_clk or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            d0_reg <= `WORD_RST;
            m0_reg <= `LANE_RST;
        end
        else if (wr1_reg)
        begin
            d0_reg <= d_in;
            m0_reg <= byte_lane_mask_n;
        end
    end

    // second word on the complement edge
    always_ff @(negedge k_clk or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            d1_reg <= `WORD_RST;
            m1_reg <= `LANE_RST;
        end
        else if (wr2_reg)
        begin
            d1_reg <= d_in;
            m1_reg <= byte_lane_mask_n;
        end
    end

    assign mif.we    = wr2_reg;
    assign mif.waddr = waddr2_reg;
    assign mif.wdata = {d1_reg, d0_reg};
    assign mif.wbe   = ~{m1_reg, m0_reg};

    always_ff @(posedge k_clk or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            q_p_reg     <= `WORD_RST;
            q_p_vld_reg <= 1'b0;
        end
        else
        begin
            case (mode)
                MODE_COMPAT:
                begin
                    q_p_reg     <= rdata_lo;
                    q_p_vld_reg <= rd1_reg;
                end
                MODE_LOOP:
                begin
                    q_p_reg     <= rbuf_hi;
                    q_p_vld_reg <= rd2_reg;
                end
                default:
                begin
                    q_p_reg     <= `WORD_RST;
                    q_p_vld_reg <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(negedge k_clk or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            q_n_reg     <= `WORD_RST;
            q_n_vld_reg <= 1'b0;
        end
        else
        begin
            q_n_reg     <= (mode == MODE_COMPAT) ? rbuf_hi : rbuf_lo;
            q_n_vld_reg <= rd2_reg;
        end
    end

    // output pair from the two edge registers
    assign q_out  = k_clk ? q_p_reg : q_n_reg;
    assign q_oe_n = k_clk ? ~q_p_vld_reg : ~q_n_vld_reg;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status_s1_reg <= `STATUS_RST;
            status_s2_reg <= `STATUS_RST;
        end
        else
        begin
            status_s1_reg <= {dll_off, single_clk_reg};
            status_s2_reg <= status_s1_reg;
        end
    end

    assign loop_off_status     = status_s2_reg[1];
    assign single_clock_status = status_s2_reg[0];

    sio_array u_array
    (
        .k_clk (k_clk),
        .port  (mif.mem)
    );

    // checks
    sequence rd_loop_s;
        rd_load && !dll_off ##1 !dll_off;
    endsequence

    sequence rd_compat_s;
        rd_load && dll_off ##1 dll_off;
    endsequence

    loop_track_a: assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        k_rst_n && !loop_disable_n ##1 !loop_disable_n |-> ##1 dll_off)
        else $error("loop not off after pin held low");

    compat_data_a: assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        rd_compat_s |-> ##1 q_p_reg == $past(rdata_lo))
        else $error("compatible mode first word wrong");

    loop_latency_a: assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        rd_loop_s |-> ##1 q_n_vld_reg ##1 q_p_vld_reg)
        else $error("read latency not one and a half cycles");

    compat_latency_a: assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        rd_compat_s |-> ##1 q_p_vld_reg && q_n_vld_reg)
        else $error("read latency not one cycle");

    access_start_a: assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        (rd1_reg || wr1_reg) |-> $past(!load_strobe_n) && !(rd1_reg && wr1_reg))
        else $error("access started without load");

    write_data_a: assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        mif.we |-> mif.wdata[`WORD_W-1:0] == $past(d_in) &&
                   mif.wbe[1:0] == ~{$past(byte_lane_mask_n[1]),
                                     $past(byte_lane_mask_n[0])})
        else $error("first write word or lanes wrong");

    write_burst_a: assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        wr_load |-> ##2 mif.we && mif.waddr == $past(address, 2))
        else $error("write burst not committed two cycles after load");

    strap_hold_a: assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        strap_done_reg |=> $stable(single_clk_reg) && strap_done_reg)
        else $error("single clock strap changed during operation");

endmodule

// ==== testbench/ctrl_model.sv ====
// Purpose: memory controller model driving the link clock, controls and write data
// Assumes: tasks are entered just after a rising k_clk edge
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps

module ctrl_model
    import ddr_sio_pkg::*;
(
    // link clock and controls
    output logic       k_clk,
    output logic       load_strobe_n,
    output logic       rw_dir,
    output addr_t      address,
    output word_t      d_in,
    output lane_t      byte_lane_mask_n,
    // read data back
    input  wire word_t q_out,
    input  wire logic  q_oe_n
);
    initial
    begin
        k_clk = 1'b0;
        load_strobe_n = 1'b1;
        rw_dir = 1'b0;
        address = 19'h00000;
        d_in = 18'h00000;
        byte_lane_mask_n = 2'h3;
    end

    // 48 ns period, far below the loop-off limit
    always #24 k_clk = ~k_clk;

    // write load, then two words on both edges
    task automatic wr(input addr_t a, input word_t w0, input word_t w1,
                      input lane_t m0, input lane_t m1);
        load_strobe_n <= 1'b0;
        rw_dir <= 1'b0;
        address <= a;
        // load taken here, first word for the next true edge
        @(posedge k_clk);
        load_strobe_n <= 1'b1;
        address <= ~a;
        d_in <= w0;
        byte_lane_mask_n <= m0;
        // second word for the complement edge
        @(posedge k_clk);
        d_in <= w1;
        byte_lane_mask_n <= m1;
    endtask

    // read load, words sampled 5 ns into each half-period
    task automatic rd(input addr_t a, input logic off, output word_t w0, output word_t w1,
                      output logic oe);
        load_strobe_n <= 1'b0;
        rw_dir <= 1'b1;
        address <= a;
        @(posedge k_clk);
        load_strobe_n <= 1'b1;
        address <= ~a;
        d_in <= ~d_in;
        // array data ready one rise after the load
        @(posedge k_clk);
        if (!off)
            @(negedge k_clk);
        #5;
        w0 = q_out;
        oe = q_oe_n;
        if (off)
            @(negedge k_clk);
        else
            @(posedge k_clk);
        #5;
        w1 = q_out;
        oe = oe | q_oe_n;
    endtask

    // load pulse that misses the true clock rise
    task automatic glitch(input addr_t a);
        @(negedge k_clk);
        load_strobe_n <= 1'b0;
        rw_dir <= 1'b1;
        address <= a;
        #10;
        load_strobe_n <= 1'b1;
    endtask
endmodule

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench for the ddr separate-io sram port
// Assumes: controller model drives the link side
// Notes: both latency modes and both strap settings are run
`timescale 1ns/1ps

module testbench
    import ddr_sio_pkg::*;
();
    logic  clk;
    logic  arst_n;
    logic  out_clk_p;
    logic  out_clk_n;
    logic  loop_disable_n;
    logic  k_clk;
    logic  load_strobe_n;
    logic  rw_dir;
    addr_t address;
    word_t d_in;
    lane_t byte_lane_mask_n;
    word_t q_out;
    logic  q_oe_n;
    logic  loop_off_status;
    logic  single_clock_status;
    int    error_cnt;
    int    total_checks;
    word_t r0;
    word_t r1;
    logic  oe;

    ctrl_model u_ctrl (.k_clk(k_clk), .load_strobe_n(load_strobe_n), .rw_dir(rw_dir),
        .address(address), .d_in(d_in), .byte_lane_mask_n(byte_lane_mask_n),
        .q_out(q_out), .q_oe_n(q_oe_n));

    ddr_sio_port u_dut (.clk(clk), .arst_n(arst_n), .k_clk(k_clk), .out_clk_p(out_clk_p),
        .out_clk_n(out_clk_n), .loop_disable_n(loop_disable_n),
        .load_strobe_n(load_strobe_n), .rw_dir(rw_dir), .address(address), .d_in(d_in),
        .byte_lane_mask_n(byte_lane_mask_n), .q_out(q_out), .q_oe_n(q_oe_n),
        .loop_off_status(loop_off_status), .single_clock_status(single_clock_status));

    initial clk = 1'b0;
    always #10 clk = ~clk;

    task automatic chk_word(input word_t got, input word_t exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask

    function automatic word_t kept_lanes(input lane_t mk);
        return {mk[1] ? 9'h1ff : 9'h000, mk[0] ? 9'h1ff : 9'h000};
    endfunction

    task automatic t_reset(input logic strap);
        @(posedge clk);
        arst_n <= 1'b0;
        out_clk_p <= strap;
        out_clk_n <= 1'b1;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (10) @(posedge k_clk);
        #5;
        chk_bit(q_oe_n, 1'b1);
        chk_bit(single_clock_status, strap);
        chk_bit(loop_off_status, ~loop_disable_n);
    endtask

    task automatic t_burst(input logic off);
        addr_t a;
        word_t w0;
        word_t w1;
        a = off ? 19'h7ffff : 19'h00000;
        w0 = off ? 18'h15a5a : 18'h2a5a5;
        w1 = ~w0;
        @(posedge clk);
        loop_disable_n <= ~off;
        repeat (6) @(posedge k_clk);
        chk_bit(loop_off_status, off);
        u_ctrl.wr(a, w0, w1, 2'h0, 2'h0);
        @(posedge k_clk);
        u_ctrl.rd(a, off, r0, r1, oe);
        chk_word(r0, w0);
        chk_word(r1, w1);
        chk_bit(oe, 1'b0);
        repeat (2) @(posedge k_clk);
        #5;
        chk_bit(q_oe_n, 1'b1);
    endtask

    task automatic t_lanes(input logic off);
        addr_t a;
        lane_t mk;
        for (int m = 0; m < 4; m++)
        begin
            a = addr_t'(16 + m);
            mk = lane_t'(m);
            @(posedge k_clk);
            u_ctrl.wr(a, 18'h3ffff, 18'h3ffff, 2'h0, 2'h0);
            @(posedge k_clk);
            u_ctrl.wr(a, 18'h00000, 18'h00000, mk, ~mk);
            @(posedge k_clk);
            u_ctrl.rd(a, off, r0, r1, oe);
            chk_word(r0, kept_lanes(mk));
            chk_word(r1, kept_lanes(~mk));
        end
    endtask

    task automatic t_raw(input logic off);
        @(posedge k_clk);
        u_ctrl.wr(19'h00100, 18'h01234, 18'h04321, 2'h0, 2'h0);
        @(posedge k_clk);
        u_ctrl.wr(19'h00100, 18'h3abcd, 18'h3dcba, 2'h0, 2'h0);
        u_ctrl.rd(19'h00100, off, r0, r1, oe);
        chk_word(r0, 18'h01234);
        chk_word(r1, 18'h04321);
        @(posedge k_clk);
        u_ctrl.rd(19'h00100, off, r0, r1, oe);
        chk_word(r0, 18'h3abcd);
        chk_word(r1, 18'h3dcba);
    endtask

    task automatic t_glitch();
        @(posedge k_clk);
        u_ctrl.glitch(19'h00100);
        repeat (6)
        begin
            @(k_clk);
            #5;
            chk_bit(q_oe_n, 1'b1);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #400000;
        error_cnt++;
        give_verdict();
    end

    initial
    begin
        arst_n = 1'b0;
        out_clk_p = 1'b0;
        out_clk_n = 1'b1;
        loop_disable_n = 1'b1;
        error_cnt = 0;
        total_checks = 0;
        t_reset(1'b0);
        t_burst(1'b0);
        t_lanes(1'b0);
        t_raw(1'b0);
        t_glitch();
        t_burst(1'b1);
        t_lanes(1'b1);
        t_raw(1'b1);
        t_reset(1'b1);
        give_verdict();
    end
endmodule
